// [iocg_pkg.sv]
`default_nettype none
package iocg_pkg;
  // gearbox configurations
  localparam logic [1:0] MODE_BY7  = 2'h0;
  localparam logic [1:0] MODE_BY8  = 2'h1;
  localparam logic [1:0] MODE_BY4  = 2'h2;
  // word widths per configuration
  localparam logic [3:0] WIDTH_BY7 = 4'h7;
  localparam logic [3:0] WIDTH_BY8 = 4'h8;
  localparam logic [3:0] WIDTH_BY4 = 4'h4;
  // structure
  localparam int SER_BITS   = 2;
  localparam int WORD_BITS  = 8;
  localparam int SHIFT_BITS = 16;
  localparam int CNT_BITS   = 5;
  localparam int NIB_BITS   = 4;
  localparam int LANES      = 2;
  localparam int LANE_A     = 0;
  localparam int LANE_C     = 1;
  // reset values
  localparam logic                 OE_INIT_DEFAULT = 1'b0;
  localparam logic [WORD_BITS-1:0] WORD_RESET      = 8'h00;
  // oe path select
  typedef enum logic [1:0] {
    OE_PATH_SDR = 2'b01,
    OE_PATH_DDR = 2'b10
  } iocg_oe_path_t;
endpackage : iocg_pkg
`default_nettype wire

// [iocg_lane.sv]
`default_nettype none
module iocg_lane
  import iocg_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [SER_BITS-1:0]  ser_in,
  input  wire logic [3:0]           width_in,
  input  wire logic                 slip_in,
  output logic      [WORD_BITS-1:0] word_out,
  output logic                      valid_out
);
  logic [SHIFT_BITS-1:0] sr_reg;
  logic [SHIFT_BITS-1:0] sr_next;
  logic [CNT_BITS-1:0]   cnt_reg;
  logic [CNT_BITS-1:0]   cnt_next;
  logic [CNT_BITS-1:0]   cnt_acc;
  logic [CNT_BITS-1:0]   shamt;
  logic [CNT_BITS-1:0]   width_ext;
  logic [SHIFT_BITS-1:0] shifted;
  logic [SHIFT_BITS-1:0] mask_wide;
  logic [WORD_BITS-1:0]  word_reg;
  logic [WORD_BITS-1:0]  word_next;
  logic                  valid_reg;
  logic                  valid_next;

  // ser_in[1] is the earlier bit; the earliest bit of a word lands in its msb
  always_comb begin
    sr_next    = {sr_reg[SHIFT_BITS-SER_BITS-1:0], ser_in};                // [RULE8]
    width_ext  = {1'b0, width_in};
    // a slip drops one serial bit, moving the boundary by exactly one bit
    cnt_acc    = cnt_reg + CNT_BITS'(SER_BITS) - {{(CNT_BITS-1){1'b0}}, slip_in}; // [RULE11]
    shamt      = cnt_acc - width_ext;
    shifted    = sr_next >> shamt;
    mask_wide  = (16'h0001 << width_in) - 16'h0001;
    word_next  = word_reg;
    valid_next = 1'b0;
    cnt_next   = cnt_acc;
    if (cnt_acc >= width_ext) begin
      word_next  = shifted[WORD_BITS-1:0] & mask_wide[WORD_BITS-1:0];   // [RULE4]
      valid_next = 1'b1;
      cnt_next   = shamt;
    end
  end

  // reset empties the shift and holding state; capture restarts on the next edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sr_reg    <= '0;                                                   // [RULE10]
      cnt_reg   <= '0;
      word_reg  <= WORD_RESET;
      valid_reg <= 1'b0;
    end else begin
      sr_reg    <= sr_next;
      cnt_reg   <= cnt_next;
      word_reg  <= word_next;
      valid_reg <= valid_next;
    end
  end

  // in 1:8 mode, from an even count a slip makes the next word a full cycle late;
  // from an odd count the dropped bit only empties the residue, so the cycle timing is unchanged
  slip_stretch_a: assert property ( // [RULE11]
    @(posedge clk_in) disable iff (!rst_n_in)
    (width_in == WIDTH_BY8 && slip_in && valid_reg && cnt_reg == '0) ##1 (!slip_in)[*3]
      |=> !valid_reg ##1 valid_reg)
    else $error("slip did not stretch the word period by one bit");

  assign word_out  = word_reg;
  assign valid_out = valid_reg;
endmodule : iocg_lane
`default_nettype wire

// [iocg_top.sv]
// Notes on behaviour
// RULE1: every output-enable control from the core passes a register before the pad buffer.
// RULE2: in single data rate the oe data input is caught in one flop that drives the pad enable.
// RULE3: in ddr memory mode on right-edge cells the oe ddr input is registered on the shifted strobe.
// RULE4: the gearbox works as a 1:7 deserialiser, one 1:8 gearbox or two 1:4 gearboxes.
// RULE5: the word sits on bits 6..0 in 1:7 mode and on bits 7..0 in 1:8 mode.
// RULE6: in dual 1:4 mode the a-position nibble is on bits 7..4 and the c-position one on 3..0.
// RULE7: the core drives a word alignment request that the gearbox uses to move the word boundary.
// RULE8: serial data is shifted in two bits per fast edge and delivered as words at the slow rate.
// RULE9: each cell register initialises set or cleared as configured and holds it at start-up; only the oe registers take OE_INIT, the rest always clear.
// RULE10: reset clears shift, holding and output state; capture resumes on the first edge after.
// RULE11: each alignment request moves the word boundary by exactly one serial bit, within cycles.
`default_nettype none
module iocg_top
  import iocg_pkg::*;
#(
  parameter bit   RIGHT_EDGE = 1'b1,
  parameter logic OE_INIT    = OE_INIT_DEFAULT
) (
  input  wire logic                 CLOCK_IN,
  input  wire logic                 NRST_IN,
  input  wire logic [SER_BITS-1:0]  SER_A_IN,
  input  wire logic [SER_BITS-1:0]  SER_C_IN,
  input  wire logic [1:0]           GEAR_MODE_IN,
  input  wire logic                 WORD_ALIGN_REQ_IN,
  output logic      [WORD_BITS-1:0] PAR_WORD_OUT,
  output logic                      WORD_VALID_OUT,
  input  wire logic                 OE_DATA_IN,
  input  wire logic                 OE_DDR_IN,
  input  wire logic                 DDR_MODE_IN,
  input  wire logic                 STROBE_WRITE_CLK_SHIFTED_IN,
  output logic                      PAD_OE_OUT
);
  logic                  align_prev_reg;
  logic                  align_prev_next;
  logic                  slip_reg;
  logic                  slip_next;
  logic [3:0]            width_sel;
  logic [3:0]            lane_width [LANES];
  logic [SER_BITS-1:0]   lane_ser   [LANES];
  logic [WORD_BITS-1:0]  lane_word  [LANES];
  logic                  lane_valid [LANES];
  logic [WORD_BITS-1:0]  par_word_reg;
  logic [WORD_BITS-1:0]  par_word_next;
  logic                  word_valid_reg;
  logic                  word_valid_next;
  logic                  mode_by7;
  logic                  mode_by8;
  logic                  mode_by4;

  assign mode_by7 = (GEAR_MODE_IN == MODE_BY7);
  assign mode_by4 = (GEAR_MODE_IN == MODE_BY4);
  assign mode_by8 = !mode_by7 && !mode_by4;

  // one slip per rising edge of the request, so a held request slips once
  always_comb begin
    align_prev_next = WORD_ALIGN_REQ_IN;
    slip_next       = WORD_ALIGN_REQ_IN && !align_prev_reg;              // [RULE7]
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      align_prev_reg <= 1'b0;
      slip_reg       <= 1'b0;
    end else begin
      align_prev_reg <= align_prev_next;
      slip_reg       <= slip_next;
    end
  end

  always_comb begin
    case (GEAR_MODE_IN)
      MODE_BY7: width_sel = WIDTH_BY7;                                   // [RULE4]
      MODE_BY4: width_sel = WIDTH_BY4;
      default:  width_sel = WIDTH_BY8;
    endcase
  end

  // lane c only matters in dual 1:4 mode; it runs at 4 bits so it stays in step
  assign lane_ser[LANE_A]   = SER_A_IN;
  assign lane_ser[LANE_C]   = SER_C_IN;
  assign lane_width[LANE_A] = width_sel;
  assign lane_width[LANE_C] = WIDTH_BY4;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    iocg_lane u_lane (
      .clk_in    (CLOCK_IN),
      .rst_n_in  (NRST_IN),
      .ser_in    (lane_ser[g]),
      .width_in  (lane_width[g]),
      .slip_in   (slip_reg),
      .word_out  (lane_word[g]),
      .valid_out (lane_valid[g])
    );
  end

  always_comb begin
    par_word_next   = par_word_reg;
    word_valid_next = lane_valid[LANE_A];
    if (lane_valid[LANE_A]) begin
      if (mode_by4) begin
        par_word_next = {lane_word[LANE_A][NIB_BITS-1:0],
                         lane_word[LANE_C][NIB_BITS-1:0]};               // [RULE6]
      end else if (mode_by7) begin
        par_word_next = {1'b0, lane_word[LANE_A][WORD_BITS-2:0]};         // [RULE5]
      end else begin
        par_word_next = lane_word[LANE_A];                               // [RULE5]
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      par_word_reg   <= WORD_RESET;                                      // [RULE10]
      word_valid_reg <= 1'b0;
    end else begin
      par_word_reg   <= par_word_next;                                   // [RULE8]
      word_valid_reg <= word_valid_next;
    end
  end

  assign PAR_WORD_OUT   = par_word_reg;
  assign WORD_VALID_OUT = word_valid_reg;

  // tri-state control path
  logic          strobe_prev_reg;
  logic          strobe_prev_next;
  logic          strobe_rise;
  logic          oe_sdr_reg;
  logic          oe_sdr_next;
  logic          oe_ddr_reg;
  logic          oe_ddr_next;
  iocg_oe_path_t oe_path;

  // the strobe is sampled as a synchronous input; its rising edge acts as the ddr clock
  assign strobe_rise = STROBE_WRITE_CLK_SHIFTED_IN && !strobe_prev_reg;
  // left/top/bottom cells have no ddr register, so ddr mode is ignored there
  assign oe_path     = (RIGHT_EDGE && DDR_MODE_IN) ? OE_PATH_DDR : OE_PATH_SDR;

  always_comb begin
    strobe_prev_next = STROBE_WRITE_CLK_SHIFTED_IN;
    oe_sdr_next      = OE_DATA_IN;                                       // [RULE2]
    oe_ddr_next      = oe_ddr_reg;
    if (strobe_rise) begin
      oe_ddr_next = OE_DDR_IN;                                           // [RULE3]
    end
  end

  // init value is a configuration constant, held until the first capture
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      strobe_prev_reg <= 1'b0;
      oe_sdr_reg      <= OE_INIT;                                        // [RULE9]
      oe_ddr_reg      <= OE_INIT;                                        // [RULE9]
    end else begin
      strobe_prev_reg <= strobe_prev_next;
      oe_sdr_reg      <= oe_sdr_next;                                    // [RULE1]
      oe_ddr_reg      <= oe_ddr_next;                                    // [RULE1]
    end
  end

  always_comb begin
    case (oe_path)
      OE_PATH_SDR: PAD_OE_OUT = oe_sdr_reg;                              // [RULE2]
      OE_PATH_DDR: PAD_OE_OUT = oe_ddr_reg;                              // [RULE3]
      default:     PAD_OE_OUT = oe_sdr_reg;
    endcase
  end

  sdr_oe_pipe_a: assert property ( // [RULE1] [RULE2]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (oe_path == OE_PATH_SDR) ##1 (oe_path == OE_PATH_SDR)
      |-> PAD_OE_OUT == $past(OE_DATA_IN))
    else $error("sdr pad enable does not follow oe data one cycle later");

  ddr_oe_capture_a: assert property ( // [RULE3]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (oe_path == OE_PATH_DDR && STROBE_WRITE_CLK_SHIFTED_IN && !strobe_prev_reg)
      ##1 (oe_path == OE_PATH_DDR) |-> PAD_OE_OUT == $past(OE_DDR_IN))
    else $error("ddr pad enable missed the strobe capture");

  ddr_oe_hold_a: assert property ( // [RULE3]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (oe_path == OE_PATH_DDR && !(STROBE_WRITE_CLK_SHIFTED_IN && !strobe_prev_reg))
      ##1 (oe_path == OE_PATH_DDR) |-> $stable(PAD_OE_OUT))
    else $error("ddr pad enable moved without a strobe edge");

  init_value_a: assert property ( // [RULE9]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    $rose(NRST_IN) |-> (PAD_OE_OUT == OE_INIT))
    else $error("pad enable not at its init value after reset");

  reset_clear_a: assert property ( // [RULE10]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    $rose(NRST_IN) |-> (PAR_WORD_OUT == WORD_RESET && !WORD_VALID_OUT))
    else $error("word output not cleared after reset");

  by7_high_a: assert property ( // [RULE5]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    mode_by7 ##1 (mode_by7 && WORD_VALID_OUT) |-> !PAR_WORD_OUT[WORD_BITS-1])
    else $error("bit 7 set in 1:7 mode");

  by8_word_a: assert property ( // [RULE4] [RULE5]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (mode_by8 && lane_valid[LANE_A]) |=> PAR_WORD_OUT == $past(lane_word[LANE_A]))
    else $error("1:8 word not passed whole");

  by4_pack_a: assert property ( // [RULE6]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (mode_by4 && lane_valid[LANE_A]) |=>
      (PAR_WORD_OUT[WORD_BITS-1:NIB_BITS] == $past(lane_word[LANE_A][NIB_BITS-1:0]) &&
       PAR_WORD_OUT[NIB_BITS-1:0] == $past(lane_word[LANE_C][NIB_BITS-1:0])))
    else $error("1:4 nibbles on the wrong bits");

  align_slip_a: assert property ( // [RULE7]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (WORD_ALIGN_REQ_IN && !align_prev_reg) |=> slip_reg ##1 !slip_reg)
    else $error("alignment request did not give one slip");

  by8_rate_a: assert property ( // [RULE8]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (mode_by8 && lane_valid[LANE_A] && !slip_reg) ##1 (mode_by8 && !slip_reg)[*3]
      |=> lane_valid[LANE_A])
    else $error("1:8 words not every four fast cycles");
endmodule : iocg_top
`default_nettype wire

// [iocg_core_model.sv]
`default_nettype none
module iocg_core_model
  import iocg_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [WORD_BITS-1:0] word_in,
  input  wire logic                 valid_in,
  input  wire logic                 slip_cmd_in,
  output var  logic                 align_req_out,
  output var  int                   words_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic go;
  initial align_req_out = 1'b0;
  // a held command alternates high and low, so requests never come closer than two edges
  always @(posedge clk_in) begin
    go = slip_cmd_in && !align_req_out;
    #2;
    align_req_out = go;
  end
  // the core only consumes words on the valid strobe
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      words_out <= 0;
    end else if (valid_in === 1'b1) begin
      words_out <= words_out + 1;
    end
  end
endmodule : iocg_core_model
`default_nettype wire

// [iocg_top_tb.sv]
`default_nettype none
module iocg_top_tb;
  import iocg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       nrst = 1'b1;
  logic [1:0] ser_a = 2'h0;
  logic [1:0] ser_c = 2'h0;
  logic [1:0] mode = 2'h1;
  logic       oe_d = 1'b0;
  logic       oe_s = 1'b0;
  logic       ddr = 1'b0;
  logic       stb = 1'b0;
  logic       slip_cmd = 1'b0;
  logic       align;
  logic [7:0] par_word;
  logic       valid;
  logic       pad_oe;
  logic       pad_oe_left;
  logic       exp_sdr, exp_ddr, exp_left, stb_prev, req_prev;
  int         words, p, skip, w;
  int         n_mismatch = 0;
  int         checks_done = 0;
  bit         qa[$];
  bit         qc[$];

  always #12.5 clk = ~clk;

  iocg_top u_iocg_top (
    .CLOCK_IN(clk), .NRST_IN(nrst), .SER_A_IN(ser_a), .SER_C_IN(ser_c),
    .GEAR_MODE_IN(mode), .WORD_ALIGN_REQ_IN(align), .PAR_WORD_OUT(par_word),
    .WORD_VALID_OUT(valid), .OE_DATA_IN(oe_d), .OE_DDR_IN(oe_s), .DDR_MODE_IN(ddr),
    .STROBE_WRITE_CLK_SHIFTED_IN(stb), .PAD_OE_OUT(pad_oe)
  );

  // left-edge cell with a set init value: the ddr select must be ignored there
  iocg_top #(.RIGHT_EDGE(1'b0), .OE_INIT(1'b1)) u_iocg_top_left (
    .CLOCK_IN(clk), .NRST_IN(nrst), .SER_A_IN(ser_a), .SER_C_IN(ser_c),
    .GEAR_MODE_IN(mode), .WORD_ALIGN_REQ_IN(align), .PAR_WORD_OUT(),
    .WORD_VALID_OUT(), .OE_DATA_IN(oe_d), .OE_DDR_IN(oe_s), .DDR_MODE_IN(ddr),
    .STROBE_WRITE_CLK_SHIFTED_IN(stb), .PAD_OE_OUT(pad_oe_left)
  );

  iocg_core_model u_iocg_core_model (
    .clk_in(clk), .rst_n_in(nrst), .word_in(par_word), .valid_in(valid),
    .slip_cmd_in(slip_cmd), .align_req_out(align), .words_out(words)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    #2;
    ser_a <= 2'($urandom);
    ser_c <= 2'($urandom);
    oe_d  <= 1'($urandom);
    oe_s  <= 1'($urandom);
    stb   <= 1'($urandom);
  end

  // reference: bit queues per lane, word start pointer, words near a slip are not compared
  always @(posedge clk) begin
    logic [7:0] e;
    if (!nrst) begin
      chk(par_word, WORD_RESET);
      chk({7'h00, valid}, 8'h00);
      chk({7'h00, pad_oe}, {7'h00, OE_INIT_DEFAULT});
      chk({7'h00, pad_oe_left}, 8'h01);
      qa.delete();
      qc.delete();
      p = 0;
      skip = 0;
      exp_sdr = OE_INIT_DEFAULT;
      exp_ddr = OE_INIT_DEFAULT;
      exp_left = 1'b1;
      stb_prev = 1'b0;
      req_prev = 1'b0;
    end else begin
      if (valid === 1'b1) begin
        e = 8'h00;
        for (int i = 0; i < w; i++) begin
          if (w == 4) begin
            e[7-i] = qa[p+i];
            e[3-i] = qc[p+i];
          end else begin
            e[w-1-i] = qa[p+i];
          end
        end
        if (skip > 0) skip--;
        else chk(par_word, e);
        p += w;
      end
      chk({7'h00, pad_oe}, {7'h00, ddr ? exp_ddr : exp_sdr});
      if (align && !req_prev) begin
        p++;
        skip = 3;
      end
      req_prev = align;
      if (stb && !stb_prev) exp_ddr = oe_s;
      stb_prev = stb;
      chk({7'h00, pad_oe_left}, {7'h00, exp_left});
      exp_sdr = oe_d;
      exp_left = oe_d;
      qa.push_back(ser_a[1]);
      qa.push_back(ser_a[0]);
      qc.push_back(ser_c[1]);
      qc.push_back(ser_c[0]);
    end
  end

  // reset lands off the clock edge in mid-stream, so each run also restarts the gearbox
  task automatic run(input logic [1:0] m, input logic d, input int cyc, input bit slips);
    nrst = 1'b0;
    mode = m;
    ddr = d;
    w = (m == MODE_BY7) ? 7 : ((m == MODE_BY4) ? 4 : 8);
    repeat (4) @(posedge clk);
    #2 nrst = 1'b1;
    for (int k = 0; k < cyc; k++) begin
      @(posedge clk);
      #2 slip_cmd = slips && (k % 16 == 8);
    end
    chk({7'h00, words >= (cyc * 2) / w - 4}, 8'h01);
  endtask : run

  initial begin
    void'($urandom(23057));
    // reset must fall after time zero so the asynchronous clear sees an edge
    #2;
    run(MODE_BY8, 1'b0, 96, 1'b0);
    // 120 cycles: the seventh slip lands on an empty bit count
    run(MODE_BY8, 1'b1, 120, 1'b1);
    run(MODE_BY7, 1'b0, 96, 1'b1);
    run(MODE_BY4, 1'b1, 64, 1'b0);
    run(2'h3, 1'b0, 48, 1'b0);
    stop_test();
  end

  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule : iocg_top_tb
`default_nettype wire
